/* bench/jrfp_host.sv */
/*
  Host model: sends queued frame bytes on the byte stream, takes answers.
  Assumes the bench pushes whole frames through put and sets slow.
*/
`timescale 1ns/1ns
module jrfp_host (
  input  wire logic  clk,
  input  wire logic  rst_n,
  input  wire logic  in_ready,
  input  wire logic  rsp_valid,
  output logic       in_valid,
  output logic [7:0] in_data,
  output logic       rsp_ready
);
  logic [7:0] q[$];
  logic       slow;
  int         wait_n;
  initial begin
    in_valid  = 1'b0;
    in_data   = 8'hA5;
    rsp_ready = 1'b0;
    slow      = 1'b0;
    wait_n    = 0;
  end
  task put(input logic [7:0] b);
    q.push_back(b);
  endtask : put
  // Held until taken; idle data toggles so no stale byte shows
  always @(posedge clk) begin
    if (!rst_n) begin
      in_valid <= 1'b0;
    end else if (!in_valid || in_ready) begin
      if (q.size() > 0) begin
        in_valid <= 1'b1;
        in_data  <= q.pop_front();
      end else begin
        in_valid <= 1'b0;
        in_data  <= ~in_data;
      end
    end
  end
  always @(posedge clk) begin
    rsp_ready <= rsp_valid && !rsp_ready && (wait_n >= (slow ? 12 : 0));
    wait_n    <= (rsp_valid && !rsp_ready) ? wait_n + 1 : 0;
  end
endmodule : jrfp_host

/* bench/jrfp_join_reg_bench.sv */
/*
  Self-checking bench of the join registration frame parser.
  Assumes the rtl folder on the include path and a small SEC_CYC.
*/
`timescale 1ns/1ns
`include "jrfp_defines.svh"
module jrfp_join_reg_bench;
  localparam int SEC = 20;
  logic               clk, rst_n, in_valid, in_ready, rsp_valid;
  logic               rsp_ready, join_valid, reg_wr, reg_rd;
  logic               cmd_valid, cmd_key_type, c_kt, e_kt;
  logic [7:0]         in_data, reg_addr, rsp_type, rsp_id, rsp_status;
  logic [7:0]         c_ty, c_id, c_st, e_id;
  logic [31:0]        reg_wdata, reg_rdata, rv;
  logic [63:0]        join_addr, cmd_addr, c_addr, e_adr, adr_a, adr_b;
  logic [4:0]         cmd_key_len, c_len, e_len;
  logic [143:0]       cmd_key, c_key, key_x, key_m;
  jrfp_pkg::jrfp_op_t cmd_op, c_op, e_op;
  logic [7:0]         key_b[18];
  int                 error_cnt, comparisons, cmd_n, rsp_n, m_c, m_r;
  int                 stall_n;

  jrfp_join_reg #(.SEC_CYC(SEC)) u_dut (
    .clk(clk), .rst_n(rst_n), .in_valid(in_valid), .in_data(in_data),
    .in_ready(in_ready), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .join_valid(join_valid), .join_addr(join_addr),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_key_type(cmd_key_type), .cmd_key_len(cmd_key_len),
    .cmd_key(cmd_key), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .rsp_type(rsp_type), .rsp_id(rsp_id), .rsp_status(rsp_status));
  jrfp_host u_host (
    .clk(clk), .rst_n(rst_n), .in_ready(in_ready), .rsp_valid(rsp_valid),
    .in_valid(in_valid), .in_data(in_data), .rsp_ready(rsp_ready));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (cmd_valid === 1'b1) begin
      cmd_n++;
      c_op = cmd_op;
      {c_addr, c_kt, c_len, c_key} =
        {cmd_addr, cmd_key_type, cmd_key_len, cmd_key};
    end
    if (in_valid === 1'b1 && in_ready === 1'b0) stall_n++;
    if (rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
      rsp_n++;
      {c_ty, c_id, c_st} = {rsp_type, rsp_id, rsp_status};
    end
  end
  task complete_run;
    if (error_cnt == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  task check(input string nm, input logic [143:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask : rd
  task rnd_key;
    foreach (key_b[i]) key_b[i] = 8'($urandom);
  endtask : rnd_key
  task frame(input logic [7:0] ty, id, input logic [63:0] adr,
             input logic [7:0] opt, input int kl, input logic bad);
    logic [7:0] b[$];
    logic [7:0] s;
    b = {ty, id};
    for (int i = 7; i >= 0; i--) b.push_back(adr[8*i+:8]);
    b.push_back(8'hFF);
    b.push_back(8'hFE);
    b.push_back(opt);
    key_x = '0;
    key_m = '0;
    for (int i = 0; i < kl; i++) begin
      b.push_back(key_b[i]);
      key_x[8*i+:8] = key_b[i];
      key_m[8*i+:8] = 8'hFF;
    end
    {e_id, e_adr, e_kt, e_len} = {id, adr, opt[0], 5'(kl)};
    e_op = (kl == 0) ? jrfp_pkg::OP_DEL : jrfp_pkg::OP_ADD;
    s = 8'h00;
    foreach (b[i]) s += b[i];
    u_host.put(`JRFP_SOF);
    u_host.put(8'h00);
    u_host.put(8'(b.size()));
    foreach (b[i]) u_host.put(b[i]);
    u_host.put((8'hFF - s) ^ {7'h00, bad});
  endtask : frame
  task settle(input int nc, nr, input logic [7:0] st);
    for (int n = 0; n < 600; n++) begin
      if (u_host.q.size() == 0 && in_valid === 1'b0 &&
          cmd_n - m_c >= nc && rsp_n - m_r >= nr) break;
      @(posedge clk);
    end
    repeat (20) @(posedge clk);
    check("cmd count", 144'(cmd_n - m_c), 144'(nc));
    check("rsp count", 144'(rsp_n - m_r), 144'(nr));
    if (nc > 0) begin
      check("cmd op", 144'(c_op), 144'(e_op));
      check("cmd addr", 144'(c_addr), 144'(e_adr));
      check("key type", 144'(c_kt), 144'(e_kt));
      check("key len", 144'(c_len), 144'(e_len));
      check("key", c_key & key_m, key_x);
    end
    if (nr > 0) begin
      check("rsp type", 144'(c_ty), 144'(`JRFP_TYPE_STAT));
      check("rsp id", 144'(c_id), 144'(e_id));
      check("rsp status", 144'(c_st), 144'(st));
    end
    m_c = cmd_n;
    m_r = rsp_n;
  endtask : settle

  initial begin
    #500000;
    error_cnt++;
    complete_run();
  end
  initial begin
    {rst_n, reg_wr, reg_rd, join_valid} = 4'h0;
    {reg_addr, reg_wdata, join_addr} = '0;
    {error_cnt, comparisons, cmd_n, rsp_n, m_c, m_r, stall_n} = '0;
    void'($urandom(32'h7864));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(`JRFP_A_CTRL);
    check("ctrl reset", 144'(rv), 144'(`JRFP_CTRL_RST));
    rd(`JRFP_A_EXP);
    check("expiry reset", 144'(rv), 144'(`JRFP_EXP_RST));
    rd(8'h40);
    check("unmapped", 144'(rv), 144'h0);
    adr_a = {$urandom, $urandom};
    adr_b = {$urandom, $urandom};
    rnd_key();
    frame(`JRFP_TYPE_REG, 8'($urandom_range(1, 255)), adr_a, 8'h00, 16, 0);
    settle(1, 1, `JRFP_ST_OK);
    frame(`JRFP_TYPE_REG, 8'h00, adr_a, 8'h00, 16, 0);
    settle(1, 0, `JRFP_ST_OK);
    rnd_key();
    frame(`JRFP_TYPE_REG, 8'h1C, adr_b, 8'h01, 18, 0);
    settle(1, 1, `JRFP_ST_OK);
    {key_b[16], key_b[17]} = {key_b[17], key_b[16]};
    frame(`JRFP_TYPE_REG, 8'h1D, adr_b, 8'h01, 18, 0);
    settle(1, 1, `JRFP_ST_OK);
    frame(`JRFP_TYPE_REG, 8'h33, adr_b, 8'h00, 17, 0);
    settle(0, 1, `JRFP_ST_FAIL);
    frame(`JRFP_TYPE_REG, 8'h34, adr_b, 8'h00, 4, 1);
    settle(0, 0, `JRFP_ST_OK);
    frame(8'h21, 8'h35, adr_b, 8'h00, 4, 0);
    settle(0, 0, `JRFP_ST_OK);
    rd(`JRFP_A_BADCNT);
    check("bad count", 144'(rv[15:0]), 144'h1);
    rd(`JRFP_A_OKCNT);
    check("ok count", 144'(rv[15:0]), 144'h5);
    u_host.put(8'h55);
    frame(`JRFP_TYPE_REG, 8'hD5, adr_a, 8'h00, 0, 0);
    settle(1, 1, `JRFP_ST_OK);
    frame(`JRFP_TYPE_REG, 8'hD6, adr_a, 8'h00, 0, 0);
    settle(0, 1, `JRFP_ST_FAIL);
    frame(`JRFP_TYPE_REG, 8'h41, `JRFP_WILD, 8'h00, 16, 0);
    settle(1, 1, `JRFP_ST_OK);
    frame(`JRFP_TYPE_REG, 8'h42, `JRFP_WILD, 8'h00, 16, 0);
    settle(0, 1, `JRFP_ST_FAIL);
    rd(`JRFP_A_STAT);
    check("wildcard", 144'(rv[4]), 144'h1);
    // Slow answers stall the parser; the buffer must lose no byte
    u_host.slow = 1'b1;
    stall_n = 0;
    frame(`JRFP_TYPE_REG, 8'h51, adr_b, 8'h00, 16, 0);
    frame(`JRFP_TYPE_REG, 8'h52, adr_b, 8'h00, 16, 0);
    settle(2, 2, `JRFP_ST_OK);
    check("stalled", 144'(stall_n > 0), 144'h1);
    u_host.slow = 1'b0;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wr(`JRFP_A_CTRL, 32'h2);
    wr(`JRFP_A_EXP, 32'hA);
    frame(`JRFP_TYPE_REG, 8'h61, adr_a, 8'h00, 16, 0);
    settle(1, 1, `JRFP_ST_OK);
    rd(`JRFP_A_STAT);
    check("timed entry", 144'(rv[3:0] != 4'h0), 144'h1);
    frame(`JRFP_TYPE_REG, 8'h62, adr_a, 8'h00, 0, 0);
    settle(0, 1, `JRFP_ST_FAIL);
    repeat (12 * SEC) @(posedge clk);
    rd(`JRFP_A_STAT);
    check("expired", 144'(rv[3:0]), 144'h0);
    frame(`JRFP_TYPE_REG, 8'h63, adr_b, 8'h00, 16, 0);
    settle(1, 1, `JRFP_ST_OK);
    join_addr  <= adr_b;
    join_valid <= 1'b1;
    @(posedge clk);
    join_valid <= 1'b0;
    rd(`JRFP_A_STAT);
    check("joined", 144'(rv[3:0]), 144'h0);
    complete_run();
  end
endmodule : jrfp_join_reg_bench

/* rtl/jrfp_buf.sv */
/*
  Small FIFO with valid and ready on both sides.
  Assumes DEPTH is a power of two, one clock, synchronous reset.
*/
`timescale 1ns/1ns
module jrfp_buf #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign in_ready  = cnt_q != FULL;
  assign out_valid = cnt_q != '0;
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
      if (push && !pop) cnt_q <= cnt_q + 1'b1;
      else if (pop && !push) cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule : jrfp_buf

/* rtl/jrfp_defines.svh */
/*
  Constants of the join registration frame parser: bytes, offsets,
  limits, register map, reset values and timing.
  Assumes inclusion by bare name from the rtl folder.
*/
`ifndef JRFP_DEFINES_SVH
`define JRFP_DEFINES_SVH
`define JRFP_SOF       8'h7E
`define JRFP_TYPE_REG  8'h24
`define JRFP_TYPE_STAT 8'hA4
`define JRFP_CSUM_OK   8'hFF
`define JRFP_POS_TYPE  6'h03
`define JRFP_POS_ID    6'h04
`define JRFP_POS_ADR0  6'h05
`define JRFP_POS_ADR7  6'h0C
`define JRFP_POS_OPT   6'h0F
`define JRFP_POS_KEY   6'h10
`define JRFP_LEN_MIN   16'h000D
`define JRFP_LEN_MAX   16'h001F
`define JRFP_LINK_MAX  5'h10
`define JRFP_IC_MAX    5'h12
`define JRFP_CRC_LEN   5'h02
`define JRFP_OPT_KT    0
`define JRFP_EO_DIST   2'h0
`define JRFP_WILD      64'hFFFF_FFFF_FFFF_FFFF
`define JRFP_ST_OK     8'h00
`define JRFP_ST_FAIL   8'h01
`define JRFP_A_CTRL    8'h00
`define JRFP_A_EXP     8'h04
`define JRFP_A_STAT    8'h08
`define JRFP_A_OKCNT   8'h0C
`define JRFP_A_BADCNT  8'h10
`define JRFP_CTRL_RST  2'h0
`define JRFP_EXP_RST   16'h012C
`define JRFP_TICK_S    1
`define JRFP_CLK_HZ    100000000
`define JRFP_SEC_CYC   (`JRFP_TICK_S * `JRFP_CLK_HZ)
`endif

/* rtl/jrfp_join_reg.sv */
/*
  Parser and actor for the joining device registration request,
  with a small table of registrant entries and expiry.
  Assumes a byte stream from logic on the same clock, a plain
  register port, and a consumer for commands and status answers.
*/
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ns
`include "jrfp_defines.svh"
// Notes on behaviour
// [RULE_01] Frame opens with one start byte
// [RULE_02] Length counts bytes before the checksum
// [RULE_03] Type byte 0x24 selects registration
// [RULE_04] Host frame id echoed in answer
// [RULE_05] Zero frame id means no answer
// [RULE_06] Host puts registrant address at offset five
// [RULE_07] Host fills reserved field with FFFE
// [RULE_08] Option bit zero picks key type
// [RULE_09] Host zeroes unassigned option bits
// [RULE_10] Link key holds at most sixteen bytes
// [RULE_11] Install code plus CRC, either order
// [RULE_12] Host copies install code unchanged
// [RULE_13] Checksum is FF minus byte sum
// [RULE_14] Nonzero id gets status answer 0xA4
// [RULE_15] Distributed mode: empty key deletes entry
// [RULE_16] Centralized mode: entries expire after timeout
// [RULE_17] All-ones address is single wildcard
// [RULE_18] Timed entry cleared when node joins
// [RULE_19] Bad checksum or length is discarded
module jrfp_join_reg #(
  parameter int ENT     = 4,
  parameter int SEC_CYC = `JRFP_SEC_CYC
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          in_valid,
  input  wire logic [7:0]    in_data,
  output logic               in_ready,
  input  wire logic [7:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic [31:0]        reg_rdata,
  input  wire logic          join_valid,
  input  wire logic [63:0]   join_addr,
  output logic               cmd_valid,
  output jrfp_pkg::jrfp_op_t cmd_op,
  output logic [63:0]        cmd_addr,
  output logic               cmd_key_type,
  output logic [4:0]         cmd_key_len,
  output logic [143:0]       cmd_key,
  output logic               rsp_valid,
  input  wire logic          rsp_ready,
  output logic [7:0]         rsp_type,
  output logic [7:0]         rsp_id,
  output logic [7:0]         rsp_status
);
  jrfp_pkg::jrfp_state_t state_q;
  logic [7:0]   b_data;
  logic         b_valid;
  logic         b_ready;
  logic         tk;
  logic         tick;
  logic [7:0]   lhi_q;
  logic [15:0]  len_q;
  logic [15:0]  len_w;
  logic [5:0]   pos_q;
  logic [7:0]   sum_q;
  logic [7:0]   csum_w;
  logic         last_w;
  logic [7:0]   type_q;
  logic [7:0]   id_q;
  logic [63:0]  addr_q;
  logic [7:0]   opt_q;
  logic [143:0] key_q;
  logic [4:0]   kidx_w;
  logic [4:0]   klen_w;
  logic [1:0]   eo_q;
  logic [15:0]  exp_q;
  logic [15:0]  okc_q;
  logic [15:0]  badc_q;
  logic         act;
  logic         is_del;
  logic         is_wild;
  logic         klen_ok;
  logic         ok_w;
  logic         hit;
  logic         free_hit;
  logic         wild_hit;
  logic [$clog2(ENT)-1:0] match_w;
  logic [$clog2(ENT)-1:0] free_w;
  logic [ENT-1:0] ent_v;
  logic [ENT-1:0] ent_t;
  logic [63:0]    ent_a [ENT];
  logic [15:0]    ent_s [ENT];

  jrfp_buf #(
    .W     (8),
    .DEPTH (2)
  ) u_buf (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (in_valid),
    .in_data   (in_data),
    .in_ready  (in_ready),
    .out_valid (b_valid),
    .out_ready (b_ready),
    .out_data  (b_data)
  );

  jrfp_tick #(
    .CYC (SEC_CYC)
  ) u_tick (
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (tick)
  );

  // Stall the stream while acting or while an answer waits
  assign b_ready = state_q != jrfp_pkg::ST_ACT &&
                   state_q != jrfp_pkg::ST_RSP;
  assign tk      = b_valid && b_ready;
  assign len_w   = {lhi_q, b_data};
  assign csum_w  = sum_q + b_data;
  // [RULE_02] Last body byte
  assign last_w  = {10'h000, pos_q} == len_q + 16'h0002;
  assign kidx_w  = 5'(pos_q - `JRFP_POS_KEY);
  assign klen_w  = 5'(len_q - `JRFP_LEN_MIN);
  assign act     = state_q == jrfp_pkg::ST_ACT;
  assign is_del  = klen_w == 5'h00;
  assign is_wild = addr_q == `JRFP_WILD;
  assign rsp_valid = state_q == jrfp_pkg::ST_RSP;
  assign rsp_type  = `JRFP_TYPE_STAT;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= jrfp_pkg::ST_SOF;
    end else begin
      case (state_q)
        // [RULE_01] Wait for start byte
        jrfp_pkg::ST_SOF:
          if (tk && b_data == `JRFP_SOF) state_q <= jrfp_pkg::ST_LHI;
        jrfp_pkg::ST_LHI:
          if (tk) state_q <= jrfp_pkg::ST_LLO;
        // [RULE_19] Length out of range dropped
        jrfp_pkg::ST_LLO:
          if (tk) begin
            if (len_w < `JRFP_LEN_MIN || len_w > `JRFP_LEN_MAX)
              state_q <= jrfp_pkg::ST_SOF;
            else state_q <= jrfp_pkg::ST_BODY;
          end
        jrfp_pkg::ST_BODY:
          if (tk && last_w) state_q <= jrfp_pkg::ST_CSUM;
        // [RULE_03] Foreign types dropped
        // [RULE_13] Checksum and type gate action
        jrfp_pkg::ST_CSUM:
          if (tk) begin
            if (csum_w == `JRFP_CSUM_OK && type_q == `JRFP_TYPE_REG)
              state_q <= jrfp_pkg::ST_ACT;
            else state_q <= jrfp_pkg::ST_SOF;
          end
        // [RULE_05] Zero id skips the answer
        jrfp_pkg::ST_ACT:
          if (id_q != 8'h00) state_q <= jrfp_pkg::ST_RSP;
          else state_q <= jrfp_pkg::ST_SOF;
        jrfp_pkg::ST_RSP:
          if (rsp_ready) state_q <= jrfp_pkg::ST_SOF;
        default: state_q <= jrfp_pkg::ST_SOF;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lhi_q <= 8'h00;
      len_q <= 16'h0000;
    end else if (tk && state_q == jrfp_pkg::ST_LHI) begin
      lhi_q <= b_data;
    end else if (tk && state_q == jrfp_pkg::ST_LLO) begin
      len_q <= len_w;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pos_q <= `JRFP_POS_TYPE;
      sum_q <= 8'h00;
    // Sum kept through CSUM: a gap before the checksum byte is legal
    end else if (state_q != jrfp_pkg::ST_BODY &&
                 state_q != jrfp_pkg::ST_CSUM) begin
      pos_q <= `JRFP_POS_TYPE;
      sum_q <= 8'h00;
    end else if (tk) begin
      pos_q <= pos_q + 6'h01;
      sum_q <= csum_w;
    end
  end

  // [RULE_06] Fields captured by byte position
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      type_q <= 8'h00;
      id_q   <= 8'h00;
      addr_q <= 64'h0;
      opt_q  <= 8'h00;
      key_q  <= 144'h0;
    end else if (tk && state_q == jrfp_pkg::ST_BODY) begin
      if (pos_q == `JRFP_POS_TYPE) type_q <= b_data;
      // [RULE_04] Keep id for the answer
      if (pos_q == `JRFP_POS_ID) id_q <= b_data;
      if (pos_q >= `JRFP_POS_ADR0 && pos_q <= `JRFP_POS_ADR7)
        addr_q <= {addr_q[55:0], b_data};
      // Reserved field is not checked
      if (pos_q == `JRFP_POS_OPT) opt_q <= b_data;
      if (pos_q >= `JRFP_POS_KEY) key_q[{kidx_w, 3'h0} +: 8] <= b_data;
    end
  end

  always_comb begin
    hit      = 1'b0;
    free_hit = 1'b0;
    wild_hit = 1'b0;
    match_w  = '0;
    free_w   = '0;
    for (int i = ENT - 1; i >= 0; i--) begin
      if (ent_v[i] && ent_a[i] == addr_q) begin
        hit     = 1'b1;
        match_w = ($clog2(ENT))'(i);
      end
      if (!ent_v[i]) begin
        free_hit = 1'b1;
        free_w   = ($clog2(ENT))'(i);
      end
      if (ent_v[i] && ent_a[i] == `JRFP_WILD) wild_hit = 1'b1;
    end
  end

  // [RULE_08] Key type from option bit zero only
  // [RULE_10] Link key up to sixteen bytes
  // [RULE_11] CRC passed as is, any byte order
  always_comb begin
    if (opt_q[`JRFP_OPT_KT])
      klen_ok = klen_w > `JRFP_CRC_LEN && klen_w <= `JRFP_IC_MAX;
    else klen_ok = klen_w <= `JRFP_LINK_MAX;
  end

  // [RULE_15] Delete only in distributed mode
  // [RULE_17] Second wildcard refused
  always_comb begin
    if (is_del) ok_w = eo_q == `JRFP_EO_DIST && hit;
    else ok_w = klen_ok && !(is_wild && wild_hit) && (hit || free_hit);
  end

  genvar g;
  generate
    for (g = 0; g < ENT; g++) begin : g_ent
      logic wr_e;
      logic clr_e;
      logic join_e;
      assign wr_e   = act && ok_w && !is_del &&
                      (hit ? match_w == g : free_w == g);
      assign clr_e  = act && ok_w && is_del && match_w == g;
      assign join_e = ent_v[g] && ent_t[g] && join_valid &&
                      join_addr == ent_a[g];
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          ent_v[g] <= 1'b0;
          ent_t[g] <= 1'b0;
          ent_a[g] <= 64'h0;
          ent_s[g] <= 16'h0000;
        end else if (wr_e) begin
          // [RULE_16] Timed unless distributed
          ent_v[g] <= 1'b1;
          ent_t[g] <= eo_q != `JRFP_EO_DIST;
          ent_a[g] <= addr_q;
          ent_s[g] <= exp_q;
        end else if (clr_e) begin
          ent_v[g] <= 1'b0;
        // [RULE_18] Join clears a timed entry
        end else if (join_e) begin
          ent_v[g] <= 1'b0;
        // [RULE_16] Count seconds down to expiry
        end else if (ent_v[g] && ent_t[g] && tick) begin
          if (ent_s[g] <= 16'h0001) ent_v[g] <= 1'b0;
          ent_s[g] <= ent_s[g] - 16'h0001;
        end
      end
      property p_expire;
        @(posedge clk) disable iff (!rst_n)
        ent_v[g] && ent_t[g] && tick && ent_s[g] == 16'h0001 &&
        !wr_e |=> !ent_v[g];
      endproperty
      a_expire: assert property (p_expire) // [RULE_16]
        else $error("timed entry did not expire");
      property p_join;
        @(posedge clk) disable iff (!rst_n)
        join_e && !wr_e |=> !ent_v[g];
      endproperty
      a_join: assert property (p_join) // [RULE_18]
        else $error("joined entry not cleared");
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmd_valid    <= 1'b0;
      cmd_op       <= jrfp_pkg::OP_ADD;
      cmd_addr     <= 64'h0;
      cmd_key_type <= 1'b0;
      cmd_key_len  <= 5'h00;
      cmd_key      <= 144'h0;
    end else begin
      cmd_valid <= act && ok_w;
      if (act && ok_w) begin
        cmd_op       <= is_del ? jrfp_pkg::OP_DEL : jrfp_pkg::OP_ADD;
        cmd_addr     <= addr_q;
        cmd_key_type <= opt_q[`JRFP_OPT_KT];
        cmd_key_len  <= klen_w;
        cmd_key      <= key_q;
      end
    end
  end

  // [RULE_14] Status answer with echoed id
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rsp_id     <= 8'h00;
      rsp_status <= `JRFP_ST_OK;
    end else if (act) begin
      rsp_id     <= id_q;
      rsp_status <= ok_w ? `JRFP_ST_OK : `JRFP_ST_FAIL;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      okc_q  <= 16'h0000;
      badc_q <= 16'h0000;
    end else begin
      if (act) okc_q <= okc_q + 16'h0001;
      if (tk && state_q == jrfp_pkg::ST_CSUM &&
          csum_w != `JRFP_CSUM_OK)
        badc_q <= badc_q + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      eo_q  <= `JRFP_CTRL_RST;
      exp_q <= `JRFP_EXP_RST;
    end else if (reg_wr) begin
      if (reg_addr == `JRFP_A_CTRL) eo_q <= reg_wdata[1:0];
      else if (reg_addr == `JRFP_A_EXP) exp_q <= reg_wdata[15:0];
    end
  end

  // Read data holds only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_n || !reg_rd) reg_rdata <= 32'h0;
    else if (reg_addr == `JRFP_A_CTRL) reg_rdata <= {30'h0, eo_q};
    else if (reg_addr == `JRFP_A_EXP) reg_rdata <= {16'h0, exp_q};
    else if (reg_addr == `JRFP_A_STAT)
      reg_rdata <= {{(31-ENT){1'b0}}, wild_hit, ent_v};
    else if (reg_addr == `JRFP_A_OKCNT) reg_rdata <= {16'h0, okc_q};
    else if (reg_addr == `JRFP_A_BADCNT) reg_rdata <= {16'h0, badc_q};
    else reg_rdata <= 32'h0;
  end

  sequence s_bad_csum;
    state_q == jrfp_pkg::ST_CSUM && tk && csum_w != `JRFP_CSUM_OK;
  endsequence
  sequence s_idle2;
    state_q == jrfp_pkg::ST_SOF ##1 !cmd_valid;
  endsequence
  property p_csum;
    @(posedge clk) disable iff (!rst_n) s_bad_csum |=> s_idle2;
  endproperty
  a_csum: assert property (p_csum) // [RULE_13]
    else $error("bad checksum frame acted on");
  property p_sof;
    @(posedge clk) disable iff (!rst_n)
    state_q == jrfp_pkg::ST_SOF && tk && b_data != `JRFP_SOF
    |=> state_q == jrfp_pkg::ST_SOF;
  endproperty
  a_sof: assert property (p_sof) // [RULE_01]
    else $error("frame opened without start byte");
  property p_len;
    @(posedge clk) disable iff (!rst_n)
    state_q == jrfp_pkg::ST_BODY && tk && last_w
    |=> state_q == jrfp_pkg::ST_CSUM &&
        {10'h000, pos_q} == len_q + 16'h0003;
  endproperty
  a_len: assert property (p_len) // [RULE_02]
    else $error("checksum not after length bytes");
  property p_range;
    @(posedge clk) disable iff (!rst_n)
    state_q == jrfp_pkg::ST_LLO && tk && len_w < `JRFP_LEN_MIN
    |=> state_q == jrfp_pkg::ST_SOF;
  endproperty
  a_range: assert property (p_range) // [RULE_19]
    else $error("short frame not discarded");
  property p_type;
    @(posedge clk) disable iff (!rst_n)
    state_q == jrfp_pkg::ST_CSUM && tk && type_q != `JRFP_TYPE_REG
    |=> s_idle2;
  endproperty
  a_type: assert property (p_type) // [RULE_03]
    else $error("foreign frame type acted on");
  property p_quiet;
    @(posedge clk) disable iff (!rst_n)
    act && id_q == 8'h00 |=> !rsp_valid [*2];
  endproperty
  a_quiet: assert property (p_quiet) // [RULE_05]
    else $error("answer for zero frame id");
  property p_rsp;
    @(posedge clk) disable iff (!rst_n)
    act && id_q != 8'h00 |=> rsp_valid && rsp_id == $past(id_q);
  endproperty
  a_rsp: assert property (p_rsp) // [RULE_14]
    else $error("missing or wrong status answer");
  property p_wild;
    @(posedge clk) disable iff (!rst_n)
    act && !is_del && is_wild && wild_hit
    |=> rsp_status == `JRFP_ST_FAIL && !cmd_valid;
  endproperty
  a_wild: assert property (p_wild) // [RULE_17]
    else $error("second wildcard accepted");
  property p_del;
    @(posedge clk) disable iff (!rst_n)
    act && is_del && eo_q == `JRFP_EO_DIST && hit
    |=> !ent_v[$past(match_w)] && cmd_op == jrfp_pkg::OP_DEL;
  endproperty
  a_del: assert property (p_del) // [RULE_15]
    else $error("empty key did not delete entry");
endmodule : jrfp_join_reg

/* rtl/jrfp_pkg.sv */
/*
  Types of the join registration frame parser.
  Assumes nothing of its surroundings.
*/
package jrfp_pkg;
  typedef enum logic [2:0] {
    ST_SOF, ST_LHI, ST_LLO, ST_BODY, ST_CSUM, ST_ACT, ST_RSP
  } jrfp_state_t;
  typedef enum logic {OP_ADD, OP_DEL} jrfp_op_t;
endpackage : jrfp_pkg

/* rtl/jrfp_tick.sv */
/*
  One-cycle tick every CYC clock cycles.
  Assumes one clock, synchronous active-low reset.
*/
`timescale 1ns/1ns
module jrfp_tick #(
  parameter int CYC = 100000000
) (
  input  wire logic clk,
  input  wire logic rst_n,
  output logic      tick
);
  localparam int W = $clog2(CYC + 1);
  localparam logic [W-1:0] LAST = W'(CYC - 1);
  logic [W-1:0] cnt_q;

  assign tick = cnt_q == LAST;

  always_ff @(posedge clk) begin
    if (!rst_n) cnt_q <= '0;
    else if (tick) cnt_q <= '0;
    else cnt_q <= cnt_q + 1'b1;
  end
endmodule : jrfp_tick
